//--- core/rot_alu.sv
// Combinational rotate datapath
`timescale 1ns/10ps
`default_nettype none
module rot_alu (
   rot_alu_if.alu a
);
   // ==========================================================
   // Rotate and flags
   // ==========================================================
   always_comb begin
      if (a.is_rlnc) begin
         a.result    = {a.operand[6:0], a.operand[7]};
         a.carry_out = a.carry_in;
      end else begin
         a.result    = {a.carry_in, a.operand[7:1]};
         a.carry_out = a.operand[0];
      end
      a.neg  = a.result[7];
      a.zero = (a.result == rot_pkg::BYTE_ZERO);
   end
endmodule : rot_alu
`default_nettype wire

//--- core/rot_alu_if.sv
// Interface between the sequencer and the rotate datapath
`timescale 1ns/10ps
`default_nettype none
interface rot_alu_if;
   logic       is_rlnc;   // Rotate left without carry
   logic [7:0] operand;   // Value read from file
   logic       carry_in;  // Present carry flag
   logic [7:0] result;    // Rotated value
   logic       carry_out; // New carry
   logic       neg;       // Negative flag
   logic       zero;      // Zero flag
   modport seq (output is_rlnc, operand, carry_in,
                input result, carry_out, neg, zero);
   modport alu (input is_rlnc, operand, carry_in,
                output result, carry_out, neg, zero);
endinterface : rot_alu_if
`default_nettype wire

//--- core/rot_pkg.sv
// Package of constants and types for the rotate instruction unit
package rot_pkg;
   // ==========================================================
   // Instruction word layout
   // ==========================================================
   localparam int          ADDR_LSB       = 0;   // File address low bit
   localparam int          ADDR_W         = 8;   // File address width
   localparam int          ACC_BIT        = 8;   // Access select bit
   localparam int          DST_BIT        = 9;   // Destination select bit
   localparam int          OPC_LSB        = 10;  // Opcode field low bit
   localparam logic [5:0]  OPC_RLNC       = 6'h11; // 0100 01
   localparam logic [5:0]  OPC_RRC        = 6'h0C; // 0011 00
   localparam logic [7:0]  IDX_LIMIT      = 8'h5F; // Indexed offset top
   localparam logic [7:0]  ACC_SPLIT      = 8'h60; // Access bank split
   localparam logic [3:0]  ACC_HIGH_BANK  = 4'hF;  // Upper access bank
   localparam logic [3:0]  ACC_LOW_BANK   = 4'h0;  // Lower access bank
   localparam logic [7:0]  BYTE_ZERO      = 8'h00; // Zero byte

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0]  REG_INSTR      = 8'h00; // Instruction word
   localparam logic [7:0]  REG_CTRL       = 8'h04; // Bank select, ext mode
   localparam logic [7:0]  REG_OPERAND    = 8'h08; // File operand value
   localparam logic [7:0]  REG_WORK       = 8'h0C; // Working register
   localparam logic [7:0]  REG_STATUS     = 8'h10; // Flags and busy
   localparam logic [7:0]  REG_RESULT     = 8'h14; // Write-back result
   localparam int          CTRL_EXT_BIT   = 8;     // Extended set enable
   localparam int          ST_C_BIT       = 0;     // Carry
   localparam int          ST_Z_BIT       = 2;     // Zero
   localparam int          ST_N_BIT       = 4;     // Negative
   localparam int          ST_BUSY_BIT    = 8;     // Cycle running
   localparam int          ST_FWR_BIT     = 9;     // File write done
   localparam int          ST_IDX_BIT     = 10;    // Indexed mode used
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Four instruction cycle phases
   typedef enum logic [1:0] {
      PH_DECODE,
      PH_READ,
      PH_PROCESS,
      PH_WRITE
   } rot_phase_e;
endpackage : rot_pkg

//--- core/rot_unit.sv
// Rotate instruction unit with AXI4-Lite register access
// Contract
// - Rotate left no carry: only N, Z change
// - Rotate right through carry: C, N, Z change
// - Destination bit 0 to W, 1 to file
// - Access bit 0 uses access bank
// - Access bit 1 uses bank select register
// - Extended set: address up to 5Fh indexed
// - One cycle: decode, read, process, write
// - Left rotate moves bit 7 to bit 0
// - Right rotate: bit 0 to C, C to bit 7
`timescale 1ns/10ps
`default_nettype none
module rot_unit (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ==========================================================
   // State
   // ==========================================================
   logic [15:0]         instr_r;      // Latched instruction word
   logic [3:0]          bank_select_reg_r; // Bank for access bit 1
   logic                ext_en_r;     // Extended set enable
   logic [7:0]          operand_r;    // File operand value
   logic [7:0]          work_r;       // Working register
   logic [7:0]          result_r;     // Last file write value
   logic                c_r;          // Carry flag
   logic                n_r;          // Negative flag
   logic                z_r;          // Zero flag
   logic                busy_r;       // Instruction running
   logic                fwr_r;        // Last result went to file
   logic                idx_r;        // Indexed offset mode seen
   logic [11:0]         ea_r;         // Resolved operand address
   logic [7:0]          opnd_q_r;     // Operand read in phase 2
   logic [7:0]          res_q_r;      // Result of phase 3
   logic                cq_r;         // Carry of phase 3
   logic                nq_r;         // Negative of phase 3
   logic                zq_r;         // Zero of phase 3
   rot_pkg::rot_phase_e phase_r;      // Current phase
   logic                aw_got_r;     // Write address held
   logic                w_got_r;      // Write data held
   logic [7:0]          awaddr_r;     // Held write address
   logic [31:0]         wdata_r;      // Held write data

   rot_alu_if alu_bus ();
   rot_alu u_alu (.a(alu_bus));

   // Decode helpers
   function automatic logic is_rlnc_f(input logic [15:0] w);
      is_rlnc_f = (w[15:rot_pkg::OPC_LSB] == rot_pkg::OPC_RLNC);
   endfunction : is_rlnc_f

   // Resolve file address; bit 12 flags indexed mode
   function automatic logic [12:0] resolve_f(input logic [15:0] w,
                                             input logic [3:0] bank_select_reg,
                                             input logic ext);
      logic [7:0] f;
      f = w[rot_pkg::ADDR_LSB +: rot_pkg::ADDR_W];
      if (w[rot_pkg::ACC_BIT]) begin
         resolve_f = {1'b0, bank_select_reg, f};
      end else if (ext && f <= rot_pkg::IDX_LIMIT) begin
         resolve_f = {1'b1, rot_pkg::ACC_LOW_BANK, f};
      end else if (f < rot_pkg::ACC_SPLIT) begin
         resolve_f = {1'b0, rot_pkg::ACC_LOW_BANK, f};
      end else begin
         resolve_f = {1'b0, rot_pkg::ACC_HIGH_BANK, f};
      end
   endfunction : resolve_f

   assign alu_bus.is_rlnc  = is_rlnc_f(instr_r);
   assign alu_bus.operand  = opnd_q_r;
   assign alu_bus.carry_in = c_r;

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   logic wr_fire;  // Both address and data present
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;

   // Accept address and data independently, answer after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= rot_pkg::BYTE_ZERO;
         wdata_r       <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= rot_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_r)
               rot_pkg::REG_INSTR, rot_pkg::REG_CTRL,
               rot_pkg::REG_OPERAND, rot_pkg::REG_WORK:
                  s_axi_bresp <= (awaddr_r == rot_pkg::REG_INSTR && busy_r)
                                 ? rot_pkg::RESP_SLVERR : rot_pkg::RESP_OKAY;
               default: s_axi_bresp <= rot_pkg::RESP_SLVERR;
            endcase
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic wstrb_ok; // Held strobes are not tracked; full word assumed
   assign wstrb_ok = 1'b1;
   logic start;  // Instruction write launches a cycle
   assign start = wr_fire && awaddr_r == rot_pkg::REG_INSTR && !busy_r
                  && wstrb_ok;

   // ==========================================================
   // Four phase instruction sequencer
   // ==========================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= rot_pkg::PH_DECODE;
         busy_r  <= 1'b0;
         instr_r <= 16'h0000;
         ea_r    <= 12'h000;
         idx_r   <= 1'b0;
         opnd_q_r <= rot_pkg::BYTE_ZERO;
         res_q_r <= rot_pkg::BYTE_ZERO;
         cq_r    <= 1'b0;
         nq_r    <= 1'b0;
         zq_r    <= 1'b0;
      end else begin
         case (phase_r)
            rot_pkg::PH_DECODE: begin
               if (start) begin
                  instr_r <= wdata_r[15:0];
                  {idx_r, ea_r} <= resolve_f(wdata_r[15:0],
                                             bank_select_reg_r, ext_en_r);
                  busy_r  <= 1'b1;
                  phase_r <= rot_pkg::PH_READ;
               end
            end
            rot_pkg::PH_READ: begin
               opnd_q_r <= operand_r;
               phase_r  <= rot_pkg::PH_PROCESS;
            end
            rot_pkg::PH_PROCESS: begin
               res_q_r <= alu_bus.result;
               cq_r    <= alu_bus.carry_out;
               nq_r    <= alu_bus.neg;
               zq_r    <= alu_bus.zero;
               phase_r <= rot_pkg::PH_WRITE;
            end
            rot_pkg::PH_WRITE: begin
               busy_r  <= 1'b0;
               phase_r <= rot_pkg::PH_DECODE;
            end
            default: phase_r <= rot_pkg::PH_DECODE;
         endcase
      end
   end

   // ==========================================================
   // Destination and flag write in phase 4
   // ==========================================================
   logic wr_phase;  // Write phase of a running instruction
   assign wr_phase = phase_r == rot_pkg::PH_WRITE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_r <= 1'b0;
         n_r <= 1'b0;
         z_r <= 1'b0;
         fwr_r <= 1'b0;
         result_r <= rot_pkg::BYTE_ZERO;
      end else if (wr_phase) begin
         c_r <= cq_r;
         n_r <= nq_r;
         z_r <= zq_r;
         fwr_r <= instr_r[rot_pkg::DST_BIT];
         if (instr_r[rot_pkg::DST_BIT]) begin
            result_r <= res_q_r;
         end
      end
   end

   // Software registers; file write-back wins over software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bank_select_reg_r <= rot_pkg::ACC_LOW_BANK;
         ext_en_r  <= 1'b0;
         operand_r <= rot_pkg::BYTE_ZERO;
         work_r    <= rot_pkg::BYTE_ZERO;
      end else begin
         if (wr_fire && awaddr_r == rot_pkg::REG_CTRL) begin
            bank_select_reg_r <= wdata_r[3:0];
            ext_en_r <= wdata_r[rot_pkg::CTRL_EXT_BIT];
         end
         if (wr_fire && awaddr_r == rot_pkg::REG_OPERAND) begin
            operand_r <= wdata_r[7:0];
         end
         if (wr_fire && awaddr_r == rot_pkg::REG_WORK) begin
            work_r <= wdata_r[7:0];
         end
         if (wr_phase && instr_r[rot_pkg::DST_BIT]) begin
            operand_r <= res_q_r;
         end else if (wr_phase) begin
            work_r <= res_q_r;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   logic [31:0] rd_val;  // Selected read word
   logic        rd_ok;   // Address is mapped
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         rot_pkg::REG_INSTR:   rd_val = {4'h0, ea_r, instr_r};
         rot_pkg::REG_CTRL:    rd_val = {23'h000000, ext_en_r, 4'h0,
                                         bank_select_reg_r};
         rot_pkg::REG_OPERAND: rd_val = {24'h000000, operand_r};
         rot_pkg::REG_WORK:    rd_val = {24'h000000, work_r};
         rot_pkg::REG_STATUS:  rd_val = {21'h000000, idx_r, fwr_r,
                                         busy_r, 3'h0, n_r, 1'b0,
                                         z_r, 1'b0, c_r};
         rot_pkg::REG_RESULT:  rd_val = {24'h000000, result_r};
         default:              rd_ok  = 1'b0;
      endcase
   end

   // Single outstanding read, answered one cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= rot_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? rot_pkg::RESP_OKAY
                                  : rot_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : rot_unit
`default_nettype wire

//--- testbench/rot_unit_checker.sv
// Bus handshake checker for the rotate unit
`timescale 1ns/10ps
`default_nettype none
module rot_unit_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ==========================================================
   // Clocking
   // ==========================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Read answer held until taken
   sequence r_wait_s;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   r_hold_a: assert property (r_wait_s |=> s_axi_rvalid
                              && $stable(s_axi_rdata))
      else $error("read answer dropped");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than a pulse");
   ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready longer than a pulse");
   r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready
                                  |=> s_axi_rvalid)
      else $error("no read answer after address");
   b_after_aw_a: assert property (s_axi_awvalid && s_axi_awready
                                  |-> ##[1:4] s_axi_bvalid)
      else $error("no write answer");
   ar_taken_a: assert property ($rose(s_axi_arvalid) |-> ##[1:3] s_axi_arready)
      else $error("read address not taken");
   err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
                                |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
endmodule : rot_unit_checker
bind rot_unit rot_unit_checker chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the rotate unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, c_exp;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   int          num_errors = 0;
   int          n_checks = 0;
   // Cases: [31:28] bank, [24] ext, [23:16] operand, [15:0] word
   localparam logic [31:0] CASES [6] = '{32'h30AB4625, 32'h30E63070,
      32'h50013310, 32'h50804580, 32'h5102325F, 32'h51004660};
   // ==========================================================
   // Clock, reset, design
   // ==========================================================
   initial begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   rot_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // ==========================================================
   // Bus tasks
   // ==========================================================
   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Write one word, both channels offered together
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   // Read one word, rready held high until the answer is taken
   task rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd_reg
   // ==========================================================
   // Scenarios
   // ==========================================================
   // Registers come up cleared
   task t_reset;
      rd_reg(rot_pkg::REG_CTRL);
      chk(rd, 32'h0);
      rd_reg(rot_pkg::REG_STATUS);
      chk(rd, 32'h0);
      chk({30'h0, resp}, {30'h0, rot_pkg::RESP_OKAY});
      $display("test reset done");
   endtask : t_reset
   // Table of rotates over opcodes, destinations and banks
   task t_rotate;
      logic [31:0] cs;
      logic [7:0]  v, f, res;
      logic [3:0]  bank;
      logic        d, idx;
      for (int i = 0; i < 6; i++) begin
         cs = CASES[i];
         v = cs[23:16];
         f = cs[7:0];
         d = cs[9];
         wr(rot_pkg::REG_CTRL, {23'h0, cs[24], 4'h0, cs[31:28]}, 2'h0);
         wr(rot_pkg::REG_OPERAND, {24'h0, v}, 2'h0);
         wr(rot_pkg::REG_WORK, 32'h5A, 2'h0);
         wr(rot_pkg::REG_INSTR, {16'h0, cs[15:0]}, 2'h0);
         // Wait for the cycle to finish, bounded
         for (int k = 0; k < 20; k++) begin
            rd_reg(rot_pkg::REG_STATUS);
            if (rd[8] === 1'b0) break;
         end
         if (cs[15:10] == rot_pkg::OPC_RLNC) begin
            res = {v[6:0], v[7]};
         end else begin
            res = {c_exp, v[7:1]};
            c_exp = v[0];
         end
         idx = cs[24] && !cs[8] && (f <= rot_pkg::IDX_LIMIT);
         bank = cs[8] ? cs[31:28] : (f < rot_pkg::ACC_SPLIT) ? 4'h0 : 4'hF;
         chk(rd, {21'h0, idx, d, 4'h0, res[7], 1'b0, res == 8'h0, 1'b0,
            c_exp});
         rd_reg(rot_pkg::REG_OPERAND);
         chk(rd, {24'h0, d ? res : v});
         rd_reg(rot_pkg::REG_WORK);
         chk(rd, {24'h0, d ? 8'h5A : res});
         rd_reg(rot_pkg::REG_INSTR);
         chk(rd, {4'h0, bank, f, cs[15:0]});
      end
      $display("test rotate done");
   endtask : t_rotate
   // Unmapped and read-only places are refused
   task t_errors;
      rd_reg(8'h18);
      chk({30'h0, resp}, {30'h0, rot_pkg::RESP_SLVERR});
      chk(rd, 32'h0);
      wr(rot_pkg::REG_STATUS, 32'h1, rot_pkg::RESP_SLVERR);
      wr(rot_pkg::REG_RESULT, 32'h1, rot_pkg::RESP_SLVERR);
      wr(8'h1C, 32'h1, rot_pkg::RESP_SLVERR);
      $display("test errors done");
   endtask : t_errors
   // Counts and verdict
   task results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   // Main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, c_exp} = '0;
      {awaddr, araddr, wdata} = '0;
      aresetn = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_rotate();
      t_errors();
      results();
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #80000;
      num_errors++;
      results();
   end
endmodule : tb_top
`default_nettype wire
